//--- spsr_host.sv
// host-side model that issues commands to the supply status block
`timescale 1ns/1ps
module spsr_host import spsr_pkg::*; (
   input wire logic clk_in,
   input wire logic rsp_valid_in,
   input wire logic [15:0] rsp_data_in,
   output logic cmd_valid_out,
   output logic [3:0] cmd_op_out,
   output logic [15:0] cmd_data_out
);
   initial begin
      cmd_valid_out = 1'b0;
      cmd_op_out = 4'h0;
      cmd_data_out = 16'h0000;
   end
   //----------------------------------------------------------------
   // one command, answer taken in the cycle after the strobe
   //----------------------------------------------------------------
   // between commands the data lines carry the inverse, not stale data
   task automatic xfer(input spsr_op_t op, input logic [15:0] d,
                       output logic [15:0] rsp);
      @(posedge clk_in);
      #1;
      cmd_valid_out = 1'b1;
      cmd_op_out = op;
      cmd_data_out = d;
      @(posedge clk_in);
      #1;
      cmd_valid_out = 1'b0;
      cmd_op_out = 4'hF;
      cmd_data_out = ~d;
      rsp = (rsp_valid_in === 1'b1) ? rsp_data_in : 16'hXXXX;
   endtask : xfer
endmodule : spsr_host

//--- spsr_map.svh
// bit positions, masks, reset values and codes of the supply status block
//----------------------------------------------------------------------
// Summary of operation
// - trigger copies triggered setpoint to active setpoint
// - over model maximum posts error -222
// - over upper limit stores the limit
// - query returns last stored triggered setpoint
// - mode command picks voltage or current regulation
// - voltage mode overcurrent switches to current, flags
// - current mode overvoltage switches to voltage, flags
// - operation live bits 8, 9, 10 only
// - status bit 7 is OR of enabled operation events
// - operation mask writable, readable, values 0..1313
// - operation events latch, read returns then clears
// - preset zeroes both live condition registers
// - questionable events latch, read clears
// - shared questionable layout bits 0,1,3,9,10,11
// - questionable live register unlatched, one is active
// - status bit 3 is OR of enabled questionable events
//----------------------------------------------------------------------
`ifndef SPSR_MAP_SVH
`define SPSR_MAP_SVH
`define SPSR_CV_BIT 8
`define SPSR_RC_BIT 9
`define SPSR_CC_BIT 10
`define SPSR_VE_BIT 0
`define SPSR_CE_BIT 1
`define SPSR_OT_BIT 3
`define SPSR_RE_BIT 9
`define SPSR_OL_BIT 10
`define SPSR_PL_BIT 11
`define SPSR_OPER_EN_MASK 16'h0521
`define SPSR_QUES_MASK 16'h0E0B
`define SPSR_OPER_LIVE_MASK 16'h0700
`define SPSR_REG_RESET 16'h0000
`define SPSR_ERR_RANGE 16'hFF22
`define SPSR_STB_OPER_BIT 7
`define SPSR_STB_QUES_BIT 3
`endif

//--- spsr_pkg.sv
// types shared by the supply status block
package spsr_pkg;
   typedef enum logic [3:0] {
      SPSR_NOP = 4'h0,
      SPSR_SET_VTRIG = 4'h1,
      SPSR_GET_VTRIG = 4'h2,
      SPSR_TRIGGER = 4'h3,
      SPSR_SET_MODE = 4'h4,
      SPSR_SET_VLIM = 4'h5,
      SPSR_GET_OCOND = 4'h6,
      SPSR_SET_OEN = 4'h7,
      SPSR_GET_OEN = 4'h8,
      SPSR_GET_OEVT = 4'h9,
      SPSR_PRESET = 4'hA,
      SPSR_GET_QEVT = 4'hB,
      SPSR_GET_QCOND = 4'hC,
      SPSR_SET_QEN = 4'hD,
      SPSR_GET_QEN = 4'hE
   } spsr_op_t;

   typedef struct packed {
      logic relay_closed;
      logic over_current;
      logic over_voltage;
      logic voltage_error;
      logic current_error;
      logic overtemperature;
      logic switch_fault;
      logic overload;
      logic power_loss;
   } spsr_pins_t;

   typedef struct packed {
      spsr_pins_t sy1;
      spsr_pins_t sy2;
      logic [15:0] vtrig;
      logic [15:0] vset;
      logic [15:0] vlim;
      logic cmd_cc;
      logic act_cc;
      logic xover_err;
      logic blocked;
      logic [15:0] ocond;
      logic [15:0] oen;
      logic [15:0] oevt;
      logic [15:0] qcond;
      logic [15:0] qen;
      logic [15:0] qevt;
      logic rsp_v;
      logic [15:0] rsp_d;
      logic err_v;
      logic [15:0] err_d;
      logic [7:0] stb;
   } spsr_state_t;
endpackage : spsr_pkg

//--- spsr_regs.sv
// status registers, triggered setpoint and mode crossover of the supply
`timescale 1ns/1ps
`include "spsr_map.svh"
module spsr_regs import spsr_pkg::*; #(
   parameter logic [15:0] VMAX = 16'hFFFF
) (
   input wire logic CORE_CLK_IN,
   input wire logic RST_IN,
   input wire logic CMD_VALID_IN,
   input wire logic [3:0] CMD_OP_IN,
   input wire logic [15:0] CMD_DATA_IN,
   input wire logic RELAY_CLOSED_IN,
   input wire logic OVER_CURRENT_IN,
   input wire logic OVER_VOLTAGE_IN,
   input wire logic VOLTAGE_ERROR_IN,
   input wire logic CURRENT_ERROR_IN,
   input wire logic OVERTEMP_IN,
   input wire logic SWITCH_FAULT_IN,
   input wire logic OVERLOAD_IN,
   input wire logic POWER_LOSS_IN,
   output logic RSP_VALID_OUT,
   output logic [15:0] RSP_DATA_OUT,
   output logic ERR_VALID_OUT,
   output logic [15:0] ERR_CODE_OUT,
   output logic [15:0] ACTIVE_VSET_OUT,
   output logic CURRENT_MODE_OUT,
   output logic CROSSOVER_ERR_OUT,
   output logic [7:0] STATUS_BYTE_OUT
);

   //-------------------------------------------------------------------
   // parameter check
   //-------------------------------------------------------------------
   if (VMAX == 16'h0000) begin : g_bad_vmax
      $error("VMAX must be above zero");
   end

   spsr_state_t q;
   spsr_state_t d;
   spsr_pins_t pins;
   spsr_op_t op;
   logic [15:0] onew;
   logic [15:0] qnew;

   assign op = spsr_op_t'(CMD_OP_IN);

   assign pins = '{relay_closed: RELAY_CLOSED_IN,
                   over_current: OVER_CURRENT_IN,
                   over_voltage: OVER_VOLTAGE_IN,
                   voltage_error: VOLTAGE_ERROR_IN,
                   current_error: CURRENT_ERROR_IN,
                   overtemperature: OVERTEMP_IN,
                   switch_fault: SWITCH_FAULT_IN,
                   overload: OVERLOAD_IN,
                   power_loss: POWER_LOSS_IN};

   function automatic logic cmd_is(input logic v, input spsr_op_t o,
                                   input spsr_op_t want);
      cmd_is = v && (o == want);
   endfunction : cmd_is

   function automatic logic [15:0] latch_evt(input logic [15:0] evt,
                                             input logic [15:0] oldc,
                                             input logic [15:0] newc,
                                             input logic clr);
      // a rising edge in the read cycle survives the clear
      latch_evt = (clr ? `SPSR_REG_RESET : evt) | (newc & ~oldc);
   endfunction : latch_evt

   //-------------------------------------------------------------------
   // next state
   //-------------------------------------------------------------------
   always_comb begin
      d = q;
      onew = `SPSR_REG_RESET;
      qnew = `SPSR_REG_RESET;
      d.sy1 = pins;
      d.sy2 = q.sy1;
      d.rsp_v = 1'b0;
      d.err_v = 1'b0;
      // crossover acts on the commanded mode and the synced limit flags
      if (!q.cmd_cc && q.sy2.over_current) begin
         d.act_cc = 1'b1;
         d.xover_err = 1'b1;
      end else if (q.cmd_cc && q.sy2.over_voltage) begin
         d.act_cc = 1'b0;
         d.xover_err = 1'b1;
      end else begin
         d.act_cc = q.cmd_cc;
         d.xover_err = 1'b0;
      end
      if (cmd_is(CMD_VALID_IN, op, SPSR_PRESET)) begin
         d.blocked = 1'b1;
      end else if (cmd_is(CMD_VALID_IN, op, SPSR_SET_OEN) ||
                   cmd_is(CMD_VALID_IN, op, SPSR_SET_QEN)) begin
         d.blocked = 1'b0;
      end
      if (!d.blocked) begin
         onew[`SPSR_CV_BIT] = !d.act_cc;
         onew[`SPSR_RC_BIT] = q.sy2.relay_closed;
         onew[`SPSR_CC_BIT] = d.act_cc;
         qnew[`SPSR_VE_BIT] = q.sy2.voltage_error ||
                              (q.cmd_cc && q.sy2.over_voltage);
         qnew[`SPSR_CE_BIT] = q.sy2.current_error ||
                              (!q.cmd_cc && q.sy2.over_current);
         qnew[`SPSR_OT_BIT] = q.sy2.overtemperature;
         qnew[`SPSR_RE_BIT] = q.sy2.switch_fault;
         qnew[`SPSR_OL_BIT] = q.sy2.overload;
         qnew[`SPSR_PL_BIT] = q.sy2.power_loss;
      end
      d.ocond = onew;
      d.qcond = qnew;
      d.oevt = latch_evt(q.oevt, q.ocond, onew,
                         cmd_is(CMD_VALID_IN, op, SPSR_GET_OEVT));
      d.qevt = latch_evt(q.qevt, q.qcond, qnew,
                         cmd_is(CMD_VALID_IN, op, SPSR_GET_QEVT));
      if (CMD_VALID_IN) begin
         case (op)
            SPSR_SET_VTRIG: begin
               if (CMD_DATA_IN > VMAX) begin
                  d.err_v = 1'b1;
                  d.err_d = `SPSR_ERR_RANGE;
               end else if (CMD_DATA_IN > q.vlim) begin
                  d.vtrig = q.vlim;
               end else begin
                  d.vtrig = CMD_DATA_IN;
               end
            end
            SPSR_GET_VTRIG: begin
               d.rsp_v = 1'b1;
               d.rsp_d = q.vtrig;
            end
            SPSR_TRIGGER: d.vset = q.vtrig;
            SPSR_SET_MODE: d.cmd_cc = CMD_DATA_IN[0];
            SPSR_SET_VLIM: d.vlim = CMD_DATA_IN;
            SPSR_GET_OCOND: begin
               d.rsp_v = 1'b1;
               d.rsp_d = q.ocond;
            end
            SPSR_SET_OEN: d.oen = CMD_DATA_IN & `SPSR_OPER_EN_MASK;
            SPSR_GET_OEN: begin
               d.rsp_v = 1'b1;
               d.rsp_d = q.oen;
            end
            SPSR_GET_OEVT: begin
               d.rsp_v = 1'b1;
               d.rsp_d = q.oevt;
            end
            SPSR_GET_QEVT: begin
               d.rsp_v = 1'b1;
               d.rsp_d = q.qevt;
            end
            SPSR_GET_QCOND: begin
               d.rsp_v = 1'b1;
               d.rsp_d = q.qcond;
            end
            SPSR_SET_QEN: d.qen = CMD_DATA_IN & `SPSR_QUES_MASK;
            SPSR_GET_QEN: begin
               d.rsp_v = 1'b1;
               d.rsp_d = q.qen;
            end
            default: d.rsp_v = 1'b0;
         endcase
      end
      d.stb = 8'h00;
      d.stb[`SPSR_STB_OPER_BIT] = |(q.oevt & q.oen);
      d.stb[`SPSR_STB_QUES_BIT] = |(q.qevt & q.qen);
   end

   //-------------------------------------------------------------------
   // state register
   //-------------------------------------------------------------------
   always_ff @(posedge CORE_CLK_IN) begin
      if (RST_IN) begin
         q <= '0;
         q.vlim <= VMAX;
      end else begin
         q <= d;
      end
   end

   assign RSP_VALID_OUT = q.rsp_v;
   assign RSP_DATA_OUT = q.rsp_d;
   assign ERR_VALID_OUT = q.err_v;
   assign ERR_CODE_OUT = q.err_d;
   assign ACTIVE_VSET_OUT = q.vset;
   assign CURRENT_MODE_OUT = q.act_cc;
   assign CROSSOVER_ERR_OUT = q.xover_err;
   assign STATUS_BYTE_OUT = q.stb;

   //-------------------------------------------------------------------
   // assertions
   //-------------------------------------------------------------------
   default clocking cb @(posedge CORE_CLK_IN); endclocking
   default disable iff (RST_IN);

   sequence trig_cmd;
      CMD_VALID_IN && op == SPSR_TRIGGER;
   endsequence

   trig_copy_a: assert property (
      trig_cmd |=> ACTIVE_VSET_OUT == $past(q.vtrig))
      else $error("trigger did not copy setpoint");
   vset_hold_a: assert property (
      !trig_cmd |=> $stable(ACTIVE_VSET_OUT))
      else $error("active setpoint moved without trigger");
   range_err_a: assert property (
      CMD_VALID_IN && op == SPSR_SET_VTRIG && CMD_DATA_IN > VMAX
      |=> ERR_VALID_OUT && ERR_CODE_OUT == `SPSR_ERR_RANGE)
      else $error("range error not posted");
   limit_clamp_a: assert property (
      CMD_VALID_IN && op == SPSR_SET_VTRIG && CMD_DATA_IN <= VMAX
      && CMD_DATA_IN > q.vlim |=> q.vtrig == $past(q.vlim))
      else $error("setpoint not clamped to limit");
   vtrig_query_a: assert property (
      CMD_VALID_IN && op == SPSR_GET_VTRIG
      |=> RSP_VALID_OUT && RSP_DATA_OUT == q.vtrig)
      else $error("triggered setpoint query wrong");
   cv_cross_a: assert property (
      !q.cmd_cc && q.sy2.over_current |=> CURRENT_MODE_OUT
      && CROSSOVER_ERR_OUT)
      else $error("no crossover to current mode");
   cc_cross_a: assert property (
      q.cmd_cc && q.sy2.over_voltage |=> !CURRENT_MODE_OUT
      && CROSSOVER_ERR_OUT)
      else $error("no crossover to voltage mode");
   oper_bits_a: assert property (
      (q.ocond & ~`SPSR_OPER_LIVE_MASK) == `SPSR_REG_RESET
      && !(q.ocond[`SPSR_CV_BIT] && q.ocond[`SPSR_CC_BIT]))
      else $error("operation live bits bad");
   oper_sum_a: assert property (
      ##1 STATUS_BYTE_OUT[7] == |($past(q.oevt) & $past(q.oen)))
      else $error("operation summary wrong");
   oen_range_a: assert property (
      q.oen <= `SPSR_OPER_EN_MASK)
      else $error("operation mask out of range");
   oevt_clear_a: assert property (
      CMD_VALID_IN && op == SPSR_GET_OEVT && !(|(onew & ~q.ocond))
      |=> q.oevt == 16'h0000)
      else $error("operation events not cleared");
   preset_zero_a: assert property (
      CMD_VALID_IN && op == SPSR_PRESET
      |=> q.ocond == 16'h0000 && q.qcond == 16'h0000)
      else $error("preset left condition bits");
   ques_sum_a: assert property (
      ##1 STATUS_BYTE_OUT[3] == |($past(q.qevt) & $past(q.qen)))
      else $error("questionable summary wrong");
   rise_latch_a: assert property (
      q.qcond[3] && !$past(q.qcond[3]) |-> q.qevt[3])
      else $error("rising condition not latched");

   //-------------------------------------------------------------------
   // event reads, layout, mode and reset
   //-------------------------------------------------------------------
   sequence oevt_read;
      CMD_VALID_IN && op == SPSR_GET_OEVT;
   endsequence

   sequence qevt_read;
      CMD_VALID_IN && op == SPSR_GET_QEVT;
   endsequence

   // a rise in the read cycle survives the clear, so it is excluded here
   qevt_clear_a: assert property (
      qevt_read ##0 !(|(qnew & ~q.qcond)) |=> q.qevt == `SPSR_REG_RESET)
      else $error("questionable events not cleared");
   qevt_answer_a: assert property (
      qevt_read |=> RSP_VALID_OUT && RSP_DATA_OUT == $past(q.qevt))
      else $error("questionable event read wrong");
   oevt_answer_a: assert property (
      oevt_read |=> RSP_VALID_OUT && RSP_DATA_OUT == $past(q.oevt))
      else $error("operation event read wrong");
   ques_bits_a: assert property (
      (q.qcond & ~`SPSR_QUES_MASK) == `SPSR_REG_RESET
      && (q.qen & ~`SPSR_QUES_MASK) == `SPSR_REG_RESET)
      else $error("questionable bits outside layout");
   ques_live_a: assert property (
      !$past(RST_IN) && !q.blocked |-> q.qcond[`SPSR_OT_BIT] ==
      $past(q.sy2.overtemperature))
      else $error("questionable live bit wrong");
   mode_set_a: assert property (
      CMD_VALID_IN && op == SPSR_SET_MODE
      |=> q.cmd_cc == $past(CMD_DATA_IN[0]))
      else $error("mode command not taken");
   mode_follow_a: assert property (
      !q.sy2.over_current && !q.sy2.over_voltage
      |=> CURRENT_MODE_OUT == $past(q.cmd_cc) && !CROSSOVER_ERR_OUT)
      else $error("actual mode left commanded mode");
   vtrig_store_a: assert property (
      CMD_VALID_IN && op == SPSR_SET_VTRIG && CMD_DATA_IN <= q.vlim
      && CMD_DATA_IN <= VMAX |=> q.vtrig == $past(CMD_DATA_IN))
      else $error("triggered setpoint not stored");
   oen_write_a: assert property (
      CMD_VALID_IN && op == SPSR_SET_OEN |=> q.oen ==
      ($past(CMD_DATA_IN) & `SPSR_OPER_EN_MASK))
      else $error("operation mask write lost");
   reset_clear_a: assert property (
      $past(RST_IN) |-> !CURRENT_MODE_OUT && STATUS_BYTE_OUT == 8'h00
      && q.oen == `SPSR_REG_RESET && q.qen == `SPSR_REG_RESET
      && q.oevt == `SPSR_REG_RESET && q.qevt == `SPSR_REG_RESET)
      else $error("reset left state behind");

endmodule : spsr_regs

//--- supply_status_and_trigger_regs_test.sv
// self-checking bench of the supply status and trigger registers
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin error_cnt++; \
   $display("wrong value at %0t: %h not %h", $time, a, b); end end
module supply_status_and_trigger_regs_test import spsr_pkg::*;;
   localparam logic [15:0] VMAX = 16'hF000;
   logic clk = 1'b0;
   logic rst = 1'b1;
   spsr_pins_t pins = '0;
   logic cmd_v, rsp_v, err_v, cur_mode, xerr;
   logic [3:0] cmd_op;
   logic [15:0] cmd_d, rsp_d, err_code, vset, r, m, lim, vexp;
   logic [15:0] seed = 16'h003F;
   logic [7:0] stb;
   int error_cnt = 0;
   int cmp_count = 0;
   int cyc = 0;
   spsr_regs #(.VMAX(VMAX)) i_spsr_regs (.CORE_CLK_IN(clk), .RST_IN(rst),
      .CMD_VALID_IN(cmd_v), .CMD_OP_IN(cmd_op), .CMD_DATA_IN(cmd_d),
      .RELAY_CLOSED_IN(pins.relay_closed),
      .OVER_CURRENT_IN(pins.over_current),
      .OVER_VOLTAGE_IN(pins.over_voltage),
      .VOLTAGE_ERROR_IN(pins.voltage_error),
      .CURRENT_ERROR_IN(pins.current_error),
      .OVERTEMP_IN(pins.overtemperature),
      .SWITCH_FAULT_IN(pins.switch_fault), .OVERLOAD_IN(pins.overload),
      .POWER_LOSS_IN(pins.power_loss), .RSP_VALID_OUT(rsp_v),
      .RSP_DATA_OUT(rsp_d), .ERR_VALID_OUT(err_v),
      .ERR_CODE_OUT(err_code), .ACTIVE_VSET_OUT(vset),
      .CURRENT_MODE_OUT(cur_mode), .CROSSOVER_ERR_OUT(xerr),
      .STATUS_BYTE_OUT(stb));
   spsr_host i_spsr_host (.clk_in(clk), .rsp_valid_in(rsp_v),
      .rsp_data_in(rsp_d), .cmd_valid_out(cmd_v), .cmd_op_out(cmd_op),
      .cmd_data_out(cmd_d));
   //----------------------------------------------------------------
   // helpers
   //----------------------------------------------------------------
   function automatic logic [15:0] xs(input logic [15:0] x);
      x ^= x << 7;
      x ^= x >> 9;
      x ^= x << 8;
      return x;
   endfunction : xs
   function automatic logic [15:0] clamp(input logic [15:0] v, l);
      return (v > l) ? l : v;
   endfunction : clamp
   // questionable layout: ve 0, ce 1, ot 3, switch fault 9, ol 10, pl 11
   function automatic logic [15:0] qexp(input spsr_pins_t p);
      qexp = 16'h0000;
      qexp[0] = p.voltage_error;
      qexp[1] = p.current_error;
      qexp[3] = p.overtemperature;
      qexp[9] = p.switch_fault;
      qexp[10] = p.overload;
      qexp[11] = p.power_loss;
   endfunction : qexp
   task automatic cmd(input spsr_op_t op, input logic [15:0] d);
      i_spsr_host.xfer(op, d, r);
   endtask : cmd
   // pins pass a two-flop sync, so give them time to reach the byte
   task automatic settle();
      repeat (6) @(posedge clk);
      #1;
   endtask : settle
   task automatic test_done();
      $display("compares %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : test_done
   initial begin
      forever #4 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 4000) begin
         error_cnt++;
         test_done();
      end
   end
   //----------------------------------------------------------------
   // main sequence
   //----------------------------------------------------------------
   initial begin
      repeat (20) @(posedge clk);
      #1;
      rst = 1'b0;
      `CHK(stb, 8'h00)
      `CHK(cur_mode, 1'b0)
      cmd(SPSR_GET_OEN, 16'h0000);
      `CHK(r, 16'h0000)
      cmd(SPSR_GET_QEN, 16'h0000);
      `CHK(r, 16'h0000)
      vexp = 16'h0000;
      for (int i = 0; i < 5; i++) begin
         seed = xs(seed);
         lim = {1'b0, seed[14:0]};
         seed = xs(seed);
         m = seed & 16'hEFFF;
         cmd(SPSR_SET_VLIM, lim);
         cmd(SPSR_SET_VTRIG, m);
         `CHK(err_v, 1'b0)
         cmd(SPSR_GET_VTRIG, 16'h0000);
         `CHK(r, clamp(m, lim))
         `CHK(vset, vexp)
         cmd(SPSR_TRIGGER, 16'h0000);
         vexp = clamp(m, lim);
         `CHK(vset, vexp)
      end
      cmd(SPSR_SET_VLIM, VMAX);
      cmd(SPSR_SET_VTRIG, VMAX + 16'h0001);
      `CHK(err_v, 1'b1)
      `CHK(err_code, 16'hFF22)
      cmd(SPSR_GET_VTRIG, 16'h0000);
      `CHK(r, vexp)
      for (int i = 0; i < 6; i++) begin
         seed = xs(seed);
         cmd(SPSR_SET_OEN, (i == 0) ? 16'h0521 : seed);
         cmd(SPSR_GET_OEN, 16'h0000);
         `CHK(r, ((i == 0) ? 16'h0521 : seed) & 16'h0521)
         cmd(SPSR_SET_QEN, seed);
         cmd(SPSR_GET_QEN, 16'h0000);
         `CHK(r, seed & 16'h0E0B)
      end
      // relay bit cannot be enabled; the cv rise after reset is unread
      cmd(SPSR_SET_OEN, 16'h0100);
      cmd(SPSR_SET_QEN, 16'h0008);
      pins.relay_closed = 1'b1;
      settle();
      `CHK(stb, 8'h80)
      cmd(SPSR_GET_OCOND, 16'h0000);
      `CHK(r & 16'hFA00, 16'h0200)
      cmd(SPSR_GET_OEVT, 16'h0000);
      `CHK(r[9], 1'b1)
      cmd(SPSR_GET_OEVT, 16'h0000);
      `CHK(r[9], 1'b0)
      settle();
      `CHK(stb[7], 1'b0)
      pins.overtemperature = 1'b1;
      settle();
      `CHK(stb[3], 1'b1)
      cmd(SPSR_GET_QCOND, 16'h0000);
      `CHK(r, 16'h0008)
      cmd(SPSR_GET_QEVT, 16'h0000);
      `CHK(r, 16'h0008)
      cmd(SPSR_GET_QEVT, 16'h0000);
      `CHK(r, 16'h0000)
      pins.overtemperature = 1'b0;
      settle();
      cmd(SPSR_GET_QCOND, 16'h0000);
      `CHK(r, 16'h0000)
      pins.over_current = 1'b1;
      settle();
      `CHK(cur_mode, 1'b1)
      `CHK(xerr, 1'b1)
      pins.over_current = 1'b0;
      cmd(SPSR_SET_MODE, 16'h0001);
      settle();
      `CHK(cur_mode, 1'b1)
      pins.over_voltage = 1'b1;
      settle();
      `CHK(cur_mode, 1'b0)
      `CHK(xerr, 1'b1)
      pins.over_voltage = 1'b0;
      cmd(SPSR_SET_MODE, 16'h0000);
      cmd(SPSR_PRESET, 16'h0000);
      settle();
      cmd(SPSR_GET_OCOND, 16'h0000);
      `CHK(r, 16'h0000)
      cmd(SPSR_GET_QCOND, 16'h0000);
      `CHK(r, 16'h0000)
      // a mask write lifts the preset block
      cmd(SPSR_SET_QEN, 16'h0E0B);
      cmd(SPSR_GET_OCOND, 16'h0000);
      `CHK(r, 16'h0300)
      for (int i = 0; i < 3; i++) begin
         seed = xs(seed);
         pins.voltage_error = seed[0];
         pins.current_error = seed[1];
         pins.overtemperature = seed[2];
         pins.switch_fault = seed[3];
         pins.overload = seed[4];
         pins.power_loss = seed[5];
         settle();
         cmd(SPSR_GET_QCOND, 16'h0000);
         `CHK(r, qexp(pins))
      end
      test_done();
   end
endmodule : supply_status_and_trigger_regs_test
